// >>> bench/pcl_ctrl_checker.sv
// Checker for pcl_ctrl, bound to the ports of its top module.
// Assumes one clock domain and the counts handed on by the bind.
`timescale 1ns/10ps
`default_nettype none

module pcl_ctrl_checker #(
  parameter int MINW_CYC = 2,
  parameter int SHDN_CYC = 100,
  parameter int SCT_CYC = 30
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Block inputs
  input wire logic enable_data_pin,
  input wire logic flash_trigger,
  input wire logic low_supply_detect,
  input wire logic output_overvoltage_guard,
  input wire logic led_short_detect,
  input wire logic die_over_limit,
  input wire logic die_below_release,
  // Block outputs
  input wire logic led_drive_on,
  input wire logic flash_active,
  input wire logic torch_active,
  input wire logic short_test_on,
  input wire logic [3:0] led_level_code,
  input wire logic low_power_shutdown,
  input wire logic [3:0] low_supply_threshold,
  input wire logic [2:0] safety_timer_length,
  input wire logic [2:0] safety_timer_current_limit
);
  logic [15:0] tcnt;
  logic [15:0] lcnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Test length and raw low run; low run saturates
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tcnt <= 16'h0000;
      lcnt <= 16'h0000;
    end else begin
      tcnt <= short_test_on ? tcnt + 16'h0001 : 16'h0000;
      if (enable_data_pin) lcnt <= 16'h0000;
      else if (lcnt != 16'hFFFF) lcnt <= lcnt + 16'h0001;
    end
  end

  chk_test_length: assert property ($rose(led_drive_on) |->
    tcnt == SCT_CYC) else $error("drive began without full test");
  chk_short_blocks: assert property ($fell(short_test_on) &&
    $past(led_short_detect) |-> !led_drive_on)
    else $error("drive despite short");
  chk_ovp_off: assert property (output_overvoltage_guard |->
    ##[1:2] !led_drive_on) else $error("drive during overvoltage");
  chk_low_supply: assert property (led_drive_on && low_supply_detect
    && low_supply_threshold != 4'h0 |-> ##[1:2] !led_drive_on)
    else $error("drive with low supply");
  chk_hot_off: assert property (die_over_limit |->
    ##[1:2] !led_drive_on) else $error("drive while hot");
  chk_shdn_entry: assert property (lcnt == SHDN_CYC + MINW_CYC + 6
    |-> low_power_shutdown) else $error("no shutdown after long low");
  chk_shdn_defaults: assert property (low_power_shutdown &&
    $past(low_power_shutdown) |-> !led_drive_on &&
    safety_timer_length == 3'h7 && low_supply_threshold == 4'h1 &&
    safety_timer_current_limit == 3'h0) else $error("shutdown state");
  chk_reg_range: assert property (safety_timer_current_limit <= 3'h5
    && low_supply_threshold <= 4'h9) else $error("register over max");
  chk_write_frame: assert property ($changed(safety_timer_length) &&
    safety_timer_length != 3'h7 |-> enable_data_pin &&
    $past(enable_data_pin, 30)) else $error("write without stop");
  chk_mode_drive: assert property (flash_active || torch_active
    |-> led_drive_on) else $error("mode without drive");

  cov_torch: cover property ($rose(led_drive_on) && torch_active);
  cov_flash: cover property ($rose(led_drive_on) && flash_active);
  cov_shdn: cover property ($rose(low_power_shutdown));
endmodule : pcl_ctrl_checker

bind pcl_ctrl pcl_ctrl_checker #(.MINW_CYC(MINW_CYC),
  .SHDN_CYC(SHDN_CYC), .SCT_CYC(SCT_CYC)) pcl_ctrl_checker_i (
  .sys_clk(sys_clk), .nrst(nrst), .enable_data_pin(enable_data_pin),
  .flash_trigger(flash_trigger), .low_supply_detect(low_supply_detect),
  .output_overvoltage_guard(output_overvoltage_guard),
  .led_short_detect(led_short_detect), .die_over_limit(die_over_limit),
  .die_below_release(die_below_release), .led_drive_on(led_drive_on),
  .flash_active(flash_active), .torch_active(torch_active),
  .short_test_on(short_test_on), .led_level_code(led_level_code),
  .low_power_shutdown(low_power_shutdown),
  .low_supply_threshold(low_supply_threshold),
  .safety_timer_length(safety_timer_length),
  .safety_timer_current_limit(safety_timer_current_limit));
`default_nettype wire

// >>> bench/pcl_host_model.sv
// Host GPIO model driving the single-wire pin.
// Assumes line timing of 20 cycles latch and 40 cycles frame end.
`timescale 1ns/10ps
`default_nettype none

module pcl_host_model (
  // Clock
  input wire logic sys_clk,
  // Single-wire pin
  output logic pin
);
  initial pin = 1'b0;

  task automatic hold(input logic lv, input int n);
    @(posedge sys_clk) pin <= lv;
    repeat (n - 1) @(posedge sys_clk);
  endtask : hold

  // Pulses of 5 low and 5 high, well above the glitch filter
  task automatic word(input int n);
    for (int i = 0; i < n; i++) begin
      hold(1'b0, 5);
      hold(1'b1, 5);
    end
  endtask : word

  // address, gap past latch, data, long stop
  task automatic frame(input int a, input int d, input int nw);
    word(a);
    hold(1'b1, 25);
    if (nw > 1) word(d);
    if (nw > 2) begin
      hold(1'b1, 25);
      word(d);
    end
    hold(1'b1, 60);
  endtask : frame
endmodule : pcl_host_model
`default_nettype wire

// >>> bench/pulse_count_led_driver_ctrl_tb_top.sv
// Testbench for pcl_ctrl with shortened line and test counts.
// Assumes a 50 MHz clock and the host model on the pin.
`timescale 1ns/10ps
`default_nettype none

module pulse_count_led_driver_ctrl_tb_top;
  logic sys_clk, nrst, flash_trigger;
  logic low_supply_detect, output_overvoltage_guard;
  logic led_short_detect, die_over_limit, die_below_release;
  wire logic enable_data_pin;
  logic led_drive_on, flash_active, torch_active, short_test_on;
  logic low_power_shutdown;
  logic [3:0] led_level_code, low_supply_threshold;
  logic [2:0] safety_timer_length, safety_timer_current_limit;
  int n_fail = 0, tests_run = 0;

  pcl_host_model pcl_host_model_i (.sys_clk(sys_clk),
    .pin(enable_data_pin));
  pcl_ctrl #(.LAT_CYC(20), .END_CYC(40), .MINW_CYC(2), .SHDN_CYC(100),
    .SCT_CYC(30)) pcl_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
    .enable_data_pin(enable_data_pin), .flash_trigger(flash_trigger),
    .low_supply_detect(low_supply_detect),
    .output_overvoltage_guard(output_overvoltage_guard),
    .led_short_detect(led_short_detect), .die_over_limit(die_over_limit),
    .die_below_release(die_below_release), .led_drive_on(led_drive_on),
    .flash_active(flash_active), .torch_active(torch_active),
    .short_test_on(short_test_on), .led_level_code(led_level_code),
    .low_power_shutdown(low_power_shutdown),
    .low_supply_threshold(low_supply_threshold),
    .safety_timer_length(safety_timer_length),
    .safety_timer_current_limit(safety_timer_current_limit));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Step past the edge so registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check

  task automatic regs(input logic [2:0] len, input logic [3:0] lb,
                      input logic [2:0] lim);
    cyc(2);
    check("length", {5'h00, len}, {5'h00, safety_timer_length});
    check("threshold", {4'h0, lb}, {4'h0, low_supply_threshold});
    check("limit", {5'h00, lim}, {5'h00, safety_timer_current_limit});
  endtask : regs

  task automatic toggle();
    @(posedge sys_clk) flash_trigger <= 1'b0;
    @(posedge sys_clk) flash_trigger <= 1'b1;
  endtask : toggle

  task automatic drive(input logic e, input int n);
    cyc(n);
    check("drive", {7'h00, e}, {7'h00, led_drive_on});
  endtask : drive

  task automatic t_reset();
    regs(3'h7, 4'h1, 3'h0);
    check("shutdown", 8'h01, {7'h00, low_power_shutdown});
    pcl_host_model_i.hold(1'b1, 20);
    check("idle", 8'h00, {7'h00, low_power_shutdown});
  endtask : t_reset

  task automatic t_write();
    pcl_host_model_i.frame(3, 5, 2);
    regs(3'h5, 4'h1, 3'h0);
    pcl_host_model_i.frame(4, 9, 2);
    pcl_host_model_i.frame(5, 5, 2);
    regs(3'h5, 4'h9, 3'h5);
    pcl_host_model_i.frame(3, 8, 2);
    pcl_host_model_i.frame(5, 6, 2);
    pcl_host_model_i.frame(6, 1, 2);
    regs(3'h5, 4'h9, 3'h5);
    pcl_host_model_i.frame(3, 2, 1);
    pcl_host_model_i.frame(3, 2, 3);
    regs(3'h5, 4'h9, 3'h5);
    pcl_host_model_i.word(3);
    pcl_host_model_i.hold(1'b0, 30);
    pcl_host_model_i.word(2);
    pcl_host_model_i.hold(1'b1, 60);
    regs(3'h5, 4'h9, 3'h5);
    // One-cycle low glitch must not count as a pulse
    pcl_host_model_i.word(3);
    pcl_host_model_i.hold(1'b0, 1);
    pcl_host_model_i.hold(1'b1, 25);
    pcl_host_model_i.word(4);
    pcl_host_model_i.hold(1'b1, 60);
    regs(3'h4, 4'h9, 3'h5);
  endtask : t_write

  task automatic t_shdn();
    pcl_host_model_i.hold(1'b0, 120);
    regs(3'h7, 4'h1, 3'h0);
    check("shutdown", 8'h01, {7'h00, low_power_shutdown});
    pcl_host_model_i.hold(1'b1, 20);
    check("idle", 8'h00, {7'h00, low_power_shutdown});
  endtask : t_shdn

  task automatic t_torch();
    pcl_host_model_i.frame(2, 19, 2);
    drive(1'b1, 40);
    check("torch", 8'h01, {7'h00, torch_active});
    check("level", 8'h03, {4'h0, led_level_code});
    pcl_host_model_i.frame(2, 3, 2);
    drive(1'b0, 5);
  endtask : t_torch

  task automatic t_flash();
    @(posedge sys_clk) led_short_detect <= 1'b1;
    flash_trigger <= 1'b1;
    cyc(3);
    check("test", 8'h01, {7'h00, short_test_on});
    drive(1'b0, 40);
    @(posedge sys_clk) flash_trigger <= 1'b0;
    led_short_detect <= 1'b0;
    toggle();
    drive(1'b1, 40);
    check("flash", 8'h01, {7'h00, flash_active});
    check("level", 8'h04, {4'h0, led_level_code});
    @(posedge sys_clk) low_supply_detect <= 1'b1;
    drive(1'b0, 3);
    @(posedge sys_clk) low_supply_detect <= 1'b0;
    drive(1'b0, 40);
    toggle();
    drive(1'b1, 40);
    @(posedge sys_clk) die_over_limit <= 1'b1;
    die_below_release <= 1'b0;
    drive(1'b0, 3);
    @(posedge sys_clk) die_over_limit <= 1'b0;
    die_below_release <= 1'b1;
    drive(1'b0, 40);
    toggle();
    drive(1'b1, 40);
    @(posedge sys_clk) output_overvoltage_guard <= 1'b1;
    drive(1'b0, 3);
    @(posedge sys_clk) output_overvoltage_guard <= 1'b0;
    drive(1'b0, 40);
    pcl_host_model_i.hold(1'b0, 8);
    pcl_host_model_i.hold(1'b1, 70);
    drive(1'b1, 1);
    @(posedge sys_clk) flash_trigger <= 1'b0;
    drive(1'b0, 3);
    pcl_host_model_i.frame(1, 22, 2);
    drive(1'b1, 40);
    check("flash", 8'h01, {7'h00, flash_active});
    check("level", 8'h06, {4'h0, led_level_code});
    pcl_host_model_i.frame(1, 6, 2);
    drive(1'b0, 5);
  endtask : t_flash

  task automatic conclude();
    if (n_fail == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    nrst <= 1'b0;
    flash_trigger <= 1'b0;
    low_supply_detect <= 1'b0;
    output_overvoltage_guard <= 1'b0;
    led_short_detect <= 1'b0;
    die_over_limit <= 1'b0;
    die_below_release <= 1'b1;
    cyc(16);
    @(posedge sys_clk) nrst <= 1'b1;
    t_reset();
    t_write();
    t_shdn();
    t_torch();
    t_flash();
    conclude();
  end

  // Whole run takes a few thousand cycles
  initial begin
    #400000;
    n_fail++;
    conclude();
  end
endmodule : pulse_count_led_driver_ctrl_tb_top
`default_nettype wire

// >>> logic/pcl_ctrl.sv
// Single-wire frame receiver, write-only registers and LED interlocks.
// Assumes synchronous pin inputs and analog comparators outside.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Low supply during flash or torch turns the LED driver off.
// - Restart after low supply needs supply back and command toggled.
// - Low supply threshold code comes from register at address 4.
// - Overvoltage latches off; cleared only by power cycle or pin low.
// - Each enable first runs a 200 us short test; short ignores command.
// - Short test result is never stored; test repeats each activation.
// - Overheat disables driver until cool and a request input toggles.
// - Pin low 405 us enters shutdown and restores register defaults.
// - Registers are write-only; nothing is read back over the pin.
// - First falling edge in idle starts a frame and clears the count.
// - Pulses count only within latch timeout, with glitch filtering.
// - High past latch timeout stores count as address, then data.
// - Stop sequence hands shadow address and data to the decoder.
// - Only one address plus one data word forms a valid frame.
// - Unknown address or out-of-range data discards the frame.
// - Addresses 1 to 5 with maxima 31, 31, 7, 9 and 5.
// - Too many pulses for the target register drops the data.
// - Idle after frame end, on rise from shutdown, or on error.
// - Pin low for the shutdown time drops frame, restores defaults.
// - Low past latch timeout but short of shutdown aborts the frame.
// - Flash register bit 4 arms flash, bits 3:0 give flash level.
// - Torch register bit 4 turns torch on, bits 3:0 give level.
// - Flash ends when flash pin is low and flash bit is clear.
module pcl_ctrl #(
  parameter int LAT_CYC = pcl_pkg::LAT_CYC,
  parameter int END_CYC = pcl_pkg::END_CYC,
  parameter int MINW_CYC = pcl_pkg::MINW_CYC,
  parameter int SHDN_CYC = pcl_pkg::SHDN_CYC,
  parameter int SCT_CYC = pcl_pkg::SCT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Host pins
  input wire logic enable_data_pin,
  input wire logic flash_trigger,
  // Analog indications
  input wire logic low_supply_detect,
  input wire logic output_overvoltage_guard,
  input wire logic led_short_detect,
  input wire logic die_over_limit,
  input wire logic die_below_release,
  // LED driver control
  output logic led_drive_on,
  output logic flash_active,
  output logic torch_active,
  output logic short_test_on,
  output logic [3:0] led_level_code,
  output logic low_power_shutdown,
  // Settings to analog side
  output logic [3:0] low_supply_threshold,
  output logic [2:0] safety_timer_length,
  output logic [2:0] safety_timer_current_limit
);

  localparam logic [pcl_pkg::RUN_W-1:0] LAT_W = pcl_pkg::RUN_W'(LAT_CYC);
  localparam logic [pcl_pkg::RUN_W-1:0] END_W = pcl_pkg::RUN_W'(END_CYC);
  localparam logic [pcl_pkg::RUN_W-1:0] SHDN_W =
    pcl_pkg::RUN_W'(SHDN_CYC);
  localparam logic [pcl_pkg::RUN_W-1:0] SCT_END =
    pcl_pkg::RUN_W'(SCT_CYC - 1);
  localparam logic [pcl_pkg::CNT_W-1:0] CNT_MAX = '1;

  // ----------------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    F_SHDN, F_IDLE, F_WORD, F_GAP, F_STOP
  } pcl_frame_e;

  typedef enum logic [1:0] {
    L_OFF, L_TEST, L_ON, L_HOLD
  } pcl_led_e;

  typedef struct packed {
    pcl_frame_e fr;
    pcl_led_e led;
    logic second;
    logic [pcl_pkg::CNT_W-1:0] cnt;
    logic [pcl_pkg::CNT_W-1:0] sh_addr;
    logic [pcl_pkg::CNT_W-1:0] sh_data;
    logic [4:0] flash_arm_and_level;
    logic [4:0] torch_enable_and_level;
    logic [2:0] safety_timer_length;
    logic [3:0] low_supply_threshold;
    logic [2:0] safety_timer_current_limit;
    logic ovp_lock;
    logic lb_lock;
    logic hot_lock;
    logic [2:0] req_q;
    logic [pcl_pkg::RUN_W-1:0] tmr;
    logic drive_on;
    logic fl_act;
    logic to_act;
    logic test_on;
    logic [3:0] level;
    logic shdn;
  } pcl_ctrl_s;

  pcl_ctrl_s q;
  pcl_ctrl_s next_q;

  logic lvl;
  logic rise;
  logic fall;
  logic [pcl_pkg::RUN_W-1:0] run;

  // ----------------------------------------------------------------------
  // Write check
  // ----------------------------------------------------------------------
  // per-register maxima
  function automatic logic wr_ok(input logic [pcl_pkg::CNT_W-1:0] a,
                                 input logic [pcl_pkg::CNT_W-1:0] d);
    logic ok;
    ok = 1'b0;
    unique case (a)
      pcl_pkg::ADDR_FLASH: ok = (d <= pcl_pkg::MAX_FLASH);
      pcl_pkg::ADDR_TORCH: ok = (d <= pcl_pkg::MAX_TORCH);
      pcl_pkg::ADDR_STLEN: ok = (d <= pcl_pkg::MAX_STLEN);
      pcl_pkg::ADDR_LBTH: ok = (d <= pcl_pkg::MAX_LBTH);
      pcl_pkg::ADDR_STLIM: ok = (d <= pcl_pkg::MAX_STLIM);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : wr_ok

  // ----------------------------------------------------------------------
  // Pin filter
  // ----------------------------------------------------------------------
  pcl_line_filter #(
    .MINW_CYC(MINW_CYC)
  ) u_filter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin(enable_data_pin),
    .lvl(lvl),
    .rise(rise),
    .fall(fall),
    .run(run)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic fl_req;
    logic to_req;
    logic any_req;
    logic chg;
    logic lock;
    logic driving;
    logic [2:0] reqv;
    fl_req = 1'b0;
    to_req = 1'b0;
    any_req = 1'b0;
    chg = 1'b0;
    lock = 1'b0;
    driving = 1'b0;
    reqv = '0;
    next_q = q;

    unique case (q.fr)
      F_SHDN: begin
        if (lvl) begin
          next_q.fr = F_IDLE;
        end
      end
      F_IDLE: begin
        if (fall) begin
          next_q.fr = F_WORD;
          next_q.cnt = '0;
          next_q.second = 1'b0;
        end
      end
      F_WORD: begin
        if (rise && q.cnt != CNT_MAX) begin
          next_q.cnt = q.cnt + 1'b1;
        end
        if (!lvl && run == LAT_W) begin
          next_q.fr = F_IDLE;
        end else if (lvl && run == LAT_W) begin
          if (!q.second) begin
            next_q.sh_addr = q.cnt;
            next_q.second = 1'b1;
            next_q.fr = F_GAP;
          end else begin
            next_q.sh_data = q.cnt;
            next_q.fr = F_STOP;
          end
        end
      end
      F_GAP: begin
        if (fall) begin
          next_q.fr = F_WORD;
          next_q.cnt = '0;
        end else if (lvl && run == END_W) begin
          next_q.fr = F_IDLE;
        end
      end
      F_STOP: begin
        if (fall) begin
          next_q.fr = F_IDLE;
        end else if (lvl && run == END_W) begin
          next_q.fr = F_IDLE;
          if (wr_ok(q.sh_addr, q.sh_data)) begin
            unique case (q.sh_addr)
              pcl_pkg::ADDR_FLASH:
                next_q.flash_arm_and_level = q.sh_data[4:0];
              pcl_pkg::ADDR_TORCH:
                next_q.torch_enable_and_level = q.sh_data[4:0];
              pcl_pkg::ADDR_STLEN:
                next_q.safety_timer_length = q.sh_data[2:0];
              pcl_pkg::ADDR_LBTH:
                next_q.low_supply_threshold = q.sh_data[3:0];
              pcl_pkg::ADDR_STLIM:
                next_q.safety_timer_current_limit = q.sh_data[2:0];
              default: begin
              end
            endcase
          end
        end
      end
    endcase

    if (!lvl && run >= SHDN_W) begin
      next_q.fr = F_SHDN;
      next_q.flash_arm_and_level = pcl_pkg::RST_FLASH;
      next_q.torch_enable_and_level = pcl_pkg::RST_TORCH;
      next_q.safety_timer_length = pcl_pkg::RST_STLEN;
      next_q.low_supply_threshold = pcl_pkg::RST_LBTH;
      next_q.safety_timer_current_limit = pcl_pkg::RST_STLIM;
    end

    fl_req = flash_trigger | q.flash_arm_and_level[pcl_pkg::EN_BIT];
    to_req = q.torch_enable_and_level[pcl_pkg::EN_BIT];
    any_req = (fl_req | to_req) & (q.fr != F_SHDN);
    reqv = {flash_trigger, q.flash_arm_and_level[pcl_pkg::EN_BIT], to_req};
    chg = (reqv != q.req_q);
    next_q.req_q = reqv;
    driving = (q.led == L_TEST) || (q.led == L_ON);

    if (output_overvoltage_guard) begin
      next_q.ovp_lock = 1'b1;
    end else if (!enable_data_pin) begin
      next_q.ovp_lock = 1'b0;
    end
    if (driving && low_supply_detect && q.low_supply_threshold != 4'h0) begin
      next_q.lb_lock = 1'b1;
    end else if (!low_supply_detect && chg) begin
      next_q.lb_lock = 1'b0;
    end
    if (die_over_limit) begin
      next_q.hot_lock = 1'b1;
    end else if (die_below_release && chg) begin
      next_q.hot_lock = 1'b0;
    end
    lock = next_q.ovp_lock | next_q.lb_lock | next_q.hot_lock;

    // LED sequencing
    unique case (q.led)
      L_OFF: begin
        if (any_req && !lock) begin
          next_q.led = L_TEST;
          next_q.tmr = '0;
        end
      end
      L_TEST: begin
        if (!any_req || lock) begin
          next_q.led = L_OFF;
        end else if (q.tmr >= SCT_END) begin
          next_q.led = led_short_detect ? L_HOLD : L_ON;
        end else begin
          next_q.tmr = q.tmr + 1'b1;
        end
      end
      L_ON: begin
        if (!any_req || lock) begin
          next_q.led = L_OFF;
        end
      end
      L_HOLD: begin
        // Command ignored until it goes away
        if (!any_req) begin
          next_q.led = L_OFF;
        end
      end
    endcase

    // Registered outputs
    next_q.drive_on = (next_q.led == L_ON);
    next_q.fl_act = next_q.drive_on & fl_req;
    next_q.to_act = next_q.drive_on & !fl_req & to_req;
    next_q.test_on = (next_q.led == L_TEST);
    next_q.level = fl_req ?
      q.flash_arm_and_level[pcl_pkg::LVL_MSB:0] :
      q.torch_enable_and_level[pcl_pkg::LVL_MSB:0];
    next_q.shdn = (next_q.fr == F_SHDN);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
      q.fr <= F_SHDN;
      q.led <= L_OFF;
      q.flash_arm_and_level <= pcl_pkg::RST_FLASH;
      q.torch_enable_and_level <= pcl_pkg::RST_TORCH;
      q.safety_timer_length <= pcl_pkg::RST_STLEN;
      q.low_supply_threshold <= pcl_pkg::RST_LBTH;
      q.safety_timer_current_limit <= pcl_pkg::RST_STLIM;
      q.level <= pcl_pkg::RST_FLASH[3:0];
      q.shdn <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign led_drive_on = q.drive_on;
  assign flash_active = q.fl_act;
  assign torch_active = q.to_act;
  assign short_test_on = q.test_on;
  assign led_level_code = q.level;
  assign low_power_shutdown = q.shdn;
  assign low_supply_threshold = q.low_supply_threshold;
  assign safety_timer_length = q.safety_timer_length;
  assign safety_timer_current_limit = q.safety_timer_current_limit;

endmodule : pcl_ctrl

`default_nettype wire

// >>> logic/pcl_line_filter.sv
// Deglitcher and edge timer for the single enable/data pin.
// Assumes the pin input is already synchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none

module pcl_line_filter #(
  parameter int MINW_CYC = pcl_pkg::MINW_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Raw pin
  input wire logic pin,
  // Filtered line
  output logic lvl,
  output logic rise,
  output logic fall,
  output logic [pcl_pkg::RUN_W-1:0] run
);

  localparam logic [pcl_pkg::STAB_W-1:0] STAB_END =
    pcl_pkg::STAB_W'(MINW_CYC - 1);
  localparam logic [pcl_pkg::RUN_W-1:0] RUN_MAX = '1;

  typedef struct packed {
    logic [pcl_pkg::STAB_W-1:0] stab;
    logic lvl;
    logic rise;
    logic fall;
    logic [pcl_pkg::RUN_W-1:0] run;
  } pcl_flt_s;

  pcl_flt_s q;
  pcl_flt_s next_q;

  // ----------------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.rise = 1'b0;
    next_q.fall = 1'b0;
    if (q.run != RUN_MAX) begin
      next_q.run = q.run + 1'b1;
    end
    if (pin != q.lvl) begin
      if (q.stab >= STAB_END) begin
        next_q.lvl = pin;
        next_q.rise = pin;
        next_q.fall = !pin;
        next_q.run = '0;
        next_q.stab = '0;
      end else begin
        next_q.stab = q.stab + 1'b1;
      end
    end else begin
      next_q.stab = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign lvl = q.lvl;
  assign rise = q.rise;
  assign fall = q.fall;
  assign run = q.run;

endmodule : pcl_line_filter

`default_nettype wire

// >>> logic/pcl_pkg.sv
// Constants of the pulse-count LED driver control block.
// Assumes a 50 MHz system clock; all times are turned into cycles here.
package pcl_pkg;

  // ----------------------------------------------------------------------
  // Clock and times
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int SHDN_US = 405;
  localparam int SHDN_CYC = SHDN_US * CLK_MHZ;
  localparam int SCT_US = 200;
  localparam int SCT_CYC = SCT_US * CLK_MHZ;
  // Line timing in cycles
  localparam int LAT_CYC = 1000;
  localparam int END_CYC = 2000;
  localparam int MINW_CYC = 10;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int RUN_W = 16;
  localparam int CNT_W = 6;
  localparam int STAB_W = 8;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FLASH = 6'h01;
  localparam logic [5:0] ADDR_TORCH = 6'h02;
  localparam logic [5:0] ADDR_STLEN = 6'h03;
  localparam logic [5:0] ADDR_LBTH = 6'h04;
  localparam logic [5:0] ADDR_STLIM = 6'h05;

  // ----------------------------------------------------------------------
  // Largest legal data per register
  // ----------------------------------------------------------------------
  localparam logic [5:0] MAX_FLASH = 6'h1F;
  localparam logic [5:0] MAX_TORCH = 6'h1F;
  localparam logic [5:0] MAX_STLEN = 6'h07;
  localparam logic [5:0] MAX_LBTH = 6'h09;
  localparam logic [5:0] MAX_STLIM = 6'h05;

  // ----------------------------------------------------------------------
  // Values after reset and shutdown
  // ----------------------------------------------------------------------
  localparam logic [4:0] RST_FLASH = 5'h04;
  localparam logic [4:0] RST_TORCH = 5'h04;
  localparam logic [2:0] RST_STLEN = 3'h7;
  localparam logic [3:0] RST_LBTH = 4'h1;
  localparam logic [2:0] RST_STLIM = 3'h0;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int EN_BIT = 4;
  localparam int LVL_MSB = 3;

endpackage : pcl_pkg
